// ===== hdl/brm_monitor.sv
module brm_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Encoder actual values
   input wire logic signed [15:0] speed_act,
   input wire logic enc_error,
   // Drive responses
   output brm_pkg::brm_resp_s resp
);
   import brm_pkg::*;

   // Speed magnitude of a signed value
   function automatic logic [15:0] magnitude(input logic signed [15:0] v);
      magnitude = v[15] ? 16'(-v) : 16'(v);
   endfunction : magnitude

   // Configuration word selected by an address
   function automatic logic [4:0] cfg_sel(input logic [11:0] a);
      logic [11:0] off;
      off = a - REG_CFG_BASE;
      cfg_sel = (a >= REG_CFG_BASE && a[1:0] == 2'b00 && off[11:2] < 10'(CFG_N)) ?
         {1'b1, off[5:2]} : 5'h00;
   endfunction : cfg_sel

   logic [6:0] ctrl_q, ctrl_d;
   logic ack_q, ack_d;
   logic [15:0] cfg_q [CFG_N];
   logic [15:0] cfg_d [CFG_N];
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d;
   logic [MON_W-1:0] mon_cnt_q, mon_cnt_d;
   logic [ACQ_W-1:0] acq_cnt_q, acq_cnt_d;
   logic [15:0] spd_q, spd_d;
   logic mon_tick;
   brm_state_e state_q, state_d;
   brm_kind_e kind_q, kind_d;
   brm_resp_s resp_d;
   logic [15:0] tcnt_q, tcnt_d, bcnt_q, bcnt_d, ramp_q, ramp_d, acc_lim_q, acc_lim_d;
   logic first_q, first_d;
   logic [4:0] div_cnt_q, div_cnt_d;
   logic [15:0] div_n_q, div_n_d, div_r_q, div_r_d;
   logic sel_one, sel_two, sel_sls, any_sel, accel_on, viol;
   logic [15:0] dly_eff, trans_dly, acc_floor, tcnt_inc;
   logic [16:0] div_rem;
   logic [31:0] first_lim, track_lim;
   logic [4:0] sel;

   // Register reads, writes and the one-cycle wait state
   always_comb begin
      ctrl_d = ctrl_q;
      ack_d = 1'b0;
      cfg_d = cfg_q;
      prdata_d = prdata;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      sel = cfg_sel(paddr);
      if (psel && penable && !pready) begin
         pready_d = 1'b1;
         pslverr_d = !(sel[4] || paddr == REG_CTRL || paddr == REG_STATUS ||
            paddr == REG_ACC_LIM || paddr == REG_RAMP);
         case (paddr)
            REG_CTRL: prdata_d = {25'h0, ctrl_q};
            REG_STATUS: prdata_d = {16'h0, 3'(state_q), 2'(kind_q), accel_on, first_q,
               2'b00, resp};
            REG_ACC_LIM: prdata_d = {16'h0, acc_lim_q};
            REG_RAMP: prdata_d = {16'h0, ramp_q};
            default: prdata_d = sel[4] ? {16'h0, cfg_q[sel[3:0]]} : 32'h0000_0000;
         endcase
      end
      // Write commits on the edge that completes the access
      if (psel && penable && pready && pwrite) begin
         if (paddr == REG_CTRL) begin
            ctrl_d = pwdata[6:0];
            ack_d = pwdata[CTL_ACK];
         end
         if (sel[4]) begin
            cfg_d[sel[3:0]] = pwdata[15:0];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
         ack_q <= 1'b0;
         for (int i = 0; i < CFG_N; i++) begin
            cfg_q[i] <= CFG_RESET;
         end
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         ack_q <= ack_d;
         cfg_q <= cfg_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
      end
   end

   // Cycle dividers and actual speed sampling
   always_comb begin
      mon_tick = (mon_cnt_q == MON_W'(MON_CLKS - 1));
      mon_cnt_d = mon_tick ? '0 : mon_cnt_q + 1'b1;
      acq_cnt_d = (acq_cnt_q == ACQ_W'(ACQ_CLKS - 1)) ? '0 : acq_cnt_q + 1'b1;
      spd_d = (acq_cnt_q == ACQ_W'(ACQ_CLKS - 1)) ? magnitude(speed_act) : spd_q;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         mon_cnt_q <= '0;
         acq_cnt_q <= '0;
         spd_q <= 16'h0000;
      end else begin
         mon_cnt_q <= mon_cnt_d;
         acq_cnt_q <= acq_cnt_d;
         spd_q <= spd_d;
      end
   end

   // Stop sequencing, ramp and acceleration monitors
   always_comb begin
      sel_one = ctrl_q[CTL_SEL_ONE] || ctrl_q[CTL_SEL_STOP_B];
      sel_two = ctrl_q[CTL_SEL_TWO] || ctrl_q[CTL_SEL_STOP_C];
      sel_sls = ctrl_q[CTL_SEL_SLS];
      any_sel = sel_one || sel_two || sel_sls;
      dly_eff = (cfg_q[CFG_RAMP_DELAY_TIME] < MIN_RAMP_DELAY) ? MIN_RAMP_DELAY :
         cfg_q[CFG_RAMP_DELAY_TIME];
      trans_dly = (kind_q == K_ONE) ? cfg_q[CFG_STOP_ONE_DELAY] : cfg_q[CFG_STOP_TWO_DELAY];
      acc_floor = (cfg_q[CFG_ACCEL_SPEED_LIMIT] == 16'h0000) ?
         cfg_q[CFG_SPEED_THRESHOLD_LIMIT] : cfg_q[CFG_ACCEL_SPEED_LIMIT];
      accel_on = (state_q == ST_DELAY || state_q == ST_RAMP) && kind_q != K_SLS &&
         !ctrl_q[CTL_ENCODERLESS] && tcnt_q < trans_dly;
      tcnt_inc = (tcnt_q == 16'hFFFF) ? tcnt_q : tcnt_q + 16'h0001;
      first_lim = 32'(spd_q) + 32'(cfg_q[CFG_ACCEL_TOL]) * 32'(FIRST_GAIN);
      track_lim = 32'(spd_q) + 32'(cfg_q[CFG_ACCEL_TOL]);
      div_rem = {div_r_q, div_n_q[15]};
      state_d = state_q;
      kind_d = kind_q;
      resp_d = resp;
      tcnt_d = tcnt_q;
      bcnt_d = bcnt_q;
      ramp_d = ramp_q;
      acc_lim_d = acc_lim_q;
      first_d = first_q;
      div_cnt_d = div_cnt_q;
      div_n_d = div_n_q;
      div_r_d = div_r_q;
      viol = 1'b0;
      // Serial divide: gradient per cycle is reference over down time
      if (div_cnt_q != 5'h00) begin
         div_cnt_d = div_cnt_q - 5'h01;
         if (div_rem >= {1'b0, cfg_q[CFG_RAMP_DOWN_TIME]}) begin
            div_rem = div_rem - {1'b0, cfg_q[CFG_RAMP_DOWN_TIME]};
            div_n_d = {div_n_q[14:0], 1'b1};
         end else begin
            div_n_d = {div_n_q[14:0], 1'b0};
         end
         div_r_d = div_rem[15:0];
      end
      case (state_q)
         ST_IDLE: begin
            if (any_sel) begin
               state_d = ST_DELAY;
               kind_d = sel_one ? K_ONE : (sel_two ? K_TWO : K_SLS);
               resp_d.quick_stop = 1'b1;
               tcnt_d = 16'h0000;
               bcnt_d = 16'h0000;
               first_d = 1'b1;
               div_cnt_d = DIV_STEPS;
               div_n_d = cfg_q[CFG_RAMP_REFERENCE_SPEED];
               div_r_d = 16'h0000;
            end
         end
         ST_DELAY, ST_RAMP: begin
            if (!any_sel) begin
               state_d = ST_IDLE;
               resp_d = '0;
            end else if (mon_tick) begin
               tcnt_d = tcnt_inc;
               if (accel_on) begin
                  first_d = 1'b0;
                  if (first_q) begin
                     acc_lim_d = (first_lim > 32'h0000_FFFF) ? 16'hFFFF : first_lim[15:0];
                  end else begin
                     if (spd_q >= acc_floor && spd_q >= cfg_q[CFG_SHUTDOWN_SPEED] &&
                        track_lim < 32'(acc_lim_q)) begin
                        acc_lim_d = track_lim[15:0];
                     end
                     viol = spd_q > acc_lim_q && spd_q >= acc_floor;
                  end
               end
               if (state_q == ST_DELAY) begin
                  if (tcnt_inc >= dly_eff) begin
                     state_d = ST_RAMP;
                     ramp_d = cfg_q[CFG_RAMP_REFERENCE_SPEED];
                  end
               end else begin
                  ramp_d = (ramp_q > div_n_q) ? ramp_q - div_n_q : 16'h0000;
                  viol = viol || spd_q > ramp_q;
                  bcnt_d = (spd_q < cfg_q[CFG_SLS_LEVEL]) ? bcnt_q + 16'h0001 : 16'h0000;
                  case (kind_q)
                     K_ONE: begin
                        if (spd_q < cfg_q[CFG_SHUTDOWN_SPEED] ||
                           tcnt_inc >= cfg_q[CFG_STOP_ONE_DELAY]) begin
                           state_d = ST_FOLLOW;
                           resp_d.torque_off = 1'b1;
                        end
                     end
                     K_TWO: begin
                        if (tcnt_inc >= cfg_q[CFG_STOP_TWO_DELAY]) begin
                           state_d = ST_FOLLOW;
                           resp_d.torque_off = 1'b1;
                        end
                     end
                     default: begin
                        if (ramp_d <= cfg_q[CFG_SLS_LEVEL] || bcnt_d >= dly_eff) begin
                           state_d = ST_FOLLOW;
                           resp_d.sls_limit_on = 1'b1;
                        end
                     end
                  endcase
               end
               if (viol) begin
                  state_d = ST_FAULT;
                  resp_d = '0;
                  resp_d.pulse_cancel = 1'b1;
                  resp_d.violation_msg = 1'b1;
               end
            end
         end
         ST_FOLLOW: begin
            if (!any_sel) begin
               state_d = ST_IDLE;
               resp_d = '0;
            end
         end
         ST_FAULT: begin
            if (ack_q && !enc_error) begin
               state_d = ST_IDLE;
               resp_d = '0;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      // Encoder error takes priority over every sequence
      if (enc_error) begin
         state_d = ST_FAULT;
         resp_d = '0;
         if (ctrl_q[CTL_NO_IMM]) begin
            resp_d.fault_stop = 1'b1;
            resp_d.timed_stop = any_sel;
         end else begin
            resp_d.pulse_cancel = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= ST_IDLE;
         kind_q <= K_ONE;
         resp <= '0;
         tcnt_q <= 16'h0000;
         bcnt_q <= 16'h0000;
         ramp_q <= 16'h0000;
         acc_lim_q <= 16'hFFFF;
         first_q <= 1'b0;
         div_cnt_q <= 5'h00;
         div_n_q <= 16'h0000;
         div_r_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         resp <= resp_d;
         tcnt_q <= tcnt_d;
         bcnt_q <= bcnt_d;
         ramp_q <= ramp_d;
         acc_lim_q <= acc_lim_d;
         first_q <= first_d;
         div_cnt_q <= div_cnt_d;
         div_n_q <= div_n_d;
         div_r_q <= div_r_d;
      end
   end

   // Checks on the monitors
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence start_seq;
      state_q == ST_IDLE && any_sel && !enc_error;
   endsequence

   AST_QUICK_STOP: assert property (start_seq |=> resp.quick_stop && state_q == ST_DELAY)
      else $error("quick stop not raised on trigger");
   AST_MIN_DELAY: assert property (state_q == ST_RAMP |-> tcnt_q >= MIN_RAMP_DELAY)
      else $error("ramp monitoring began too early");
   AST_EXACT_DELAY: assert property ($rose(state_q == ST_RAMP) |-> tcnt_q == dly_eff)
      else $error("ramp delay not applied exactly");
   AST_RAMP_VIOL: assert property (state_q == ST_RAMP && mon_tick && any_sel && !enc_error &&
      spd_q > ramp_q |=> resp.pulse_cancel && resp.violation_msg)
      else $error("ramp violation not answered");
   AST_FIRST_LIM: assert property (accel_on && first_q && mon_tick && any_sel && !enc_error
      && first_lim < 32'h0001_0000 |=> acc_lim_q == 16'($past(first_lim)))
      else $error("first cycle limit wrong");
   AST_NO_RISE: assert property (accel_on && !first_q && mon_tick |=> acc_lim_q <= $past(acc_lim_q))
      else $error("acceleration limit rose");
   AST_ENC_OPT: assert property (enc_error && ctrl_q[CTL_NO_IMM] |=>
      resp.fault_stop && !resp.pulse_cancel)
      else $error("encoder error option ignored");
   AST_TIMED: assert property (resp.timed_stop |-> state_q == ST_FAULT && !accel_on)
      else $error("timed stop still monitored");
   AST_FOLLOW: assert property ($rose(resp.sls_limit_on) |-> kind_q == K_SLS &&
      state_q == ST_FOLLOW)
      else $error("limit follow-on without sls");
   AST_STOP_TWO_END: assert property (state_q == ST_RAMP && kind_q == K_TWO && mon_tick &&
      any_sel && !enc_error && tcnt_inc >= cfg_q[CFG_STOP_TWO_DELAY] && !viol
      |=> resp.torque_off ##0 state_q == ST_FOLLOW)
      else $error("stop two ramp did not end");
endmodule : brm_monitor

// ===== hdl/brm_pkg.sv
package brm_pkg;
   // Clock and cycle timing
   localparam int CLK_NS = 4;
   localparam int MON_CYCLE_NS = 12000;
   localparam int ACQ_CYCLE_NS = 1000;
   localparam int MON_CLKS = MON_CYCLE_NS / CLK_NS;
   localparam int ACQ_CLKS = ACQ_CYCLE_NS / CLK_NS;
   localparam int FIRST_GAIN = MON_CYCLE_NS / ACQ_CYCLE_NS;
   localparam int MON_W = 12;
   localparam int ACQ_W = 8;
   localparam logic [15:0] MIN_RAMP_DELAY = 16'h0002;
   localparam logic [4:0] DIV_STEPS = 5'h10;

   // Register byte addresses
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_ACC_LIM = 12'h008;
   localparam logic [11:0] REG_RAMP = 12'h00C;
   localparam logic [11:0] REG_CFG_BASE = 12'h010;
   localparam int CFG_N = 10;

   // Configuration word indices
   localparam int CFG_ACCEL_TOL = 0;
   localparam int CFG_ACCEL_SPEED_LIMIT = 1;
   localparam int CFG_SPEED_THRESHOLD_LIMIT = 2;
   localparam int CFG_SHUTDOWN_SPEED = 3;
   localparam int CFG_STOP_ONE_DELAY = 4;
   localparam int CFG_STOP_TWO_DELAY = 5;
   localparam int CFG_RAMP_REFERENCE_SPEED = 6;
   localparam int CFG_RAMP_DELAY_TIME = 7;
   localparam int CFG_RAMP_DOWN_TIME = 8;
   localparam int CFG_SLS_LEVEL = 9;
   localparam logic [15:0] CFG_RESET = 16'h0000;

   // Control register bits
   localparam int CTL_SEL_ONE = 0;
   localparam int CTL_SEL_TWO = 1;
   localparam int CTL_SEL_SLS = 2;
   localparam int CTL_SEL_STOP_B = 3;
   localparam int CTL_SEL_STOP_C = 4;
   localparam int CTL_ENCODERLESS = 5;
   localparam int CTL_NO_IMM = 6;
   localparam int CTL_ACK = 7;
   localparam logic [6:0] CTRL_RESET = 7'h00;

   typedef enum {ST_IDLE, ST_DELAY, ST_RAMP, ST_FOLLOW, ST_FAULT} brm_state_e;
   typedef enum {K_ONE, K_TWO, K_SLS} brm_kind_e;

   // Drive responses
   typedef struct packed {
      logic quick_stop;
      logic torque_off;
      logic sls_limit_on;
      logic pulse_cancel;
      logic violation_msg;
      logic fault_stop;
      logic timed_stop;
   } brm_resp_s;
endpackage : brm_pkg

// ===== dv/brm_drive_model.sv
module brm_drive_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Stop commands and bench settings
   input wire brm_pkg::brm_resp_s resp,
   input wire logic signed [15:0] set_speed,
   input wire logic [15:0] decel,
   input wire logic enc_fault,
   // Encoder actual values
   output logic signed [15:0] speed_act,
   output logic enc_error
);
   timeunit 1ns;
   timeprecision 1ps;
   import brm_pkg::*;
   int acq;
   logic signed [15:0] step;
   // Encoder fault passes straight through
   assign enc_error = enc_fault;
   assign step = $signed(decel);
   // New actual value once per acquisition cycle
   always @(posedge clock) begin
      acq <= (rst || acq == ACQ_CLKS - 1) ? 0 : acq + 1;
      if (rst) begin
         speed_act <= 16'h0000;
      end else if (acq == 0) begin
         if (!resp.quick_stop || decel == 16'h0000) begin
            speed_act <= set_speed;
         end else if (speed_act > step) begin
            speed_act <= speed_act - step;
         end else if (speed_act < -step) begin
            speed_act <= speed_act + step;
         end else begin
            speed_act <= 16'h0000;
         end
      end
   end
endmodule : brm_drive_model

// ===== dv/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import brm_pkg::*;
   // 116 rev/s2 over 12 ms is 84 rpm, plus a fifth
   localparam int TOL = 100;
   localparam logic [6:0] QS = 7'h40, TQ = 7'h20, SL = 7'h10, PC = 7'h08;
   localparam logic [6:0] VM = 7'h04, FS = 7'h02, TS = 7'h01;
   localparam logic [2:0] S_IDL = 3'h0, S_DLY = 3'h1, S_RMP = 3'h2, S_FOL = 3'h3, S_FLT = 3'h4;
   // Bench signals
   logic clock, rst, psel, penable, pwrite, pready, pslverr, enc_error, enc_fault, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat, r0;
   logic signed [15:0] speed_act, set_speed;
   logic [15:0] decel;
   brm_resp_s resp;
   int cyc, num_errors, total_checks;
   logic [15:0] cfg_v [CFG_N] = '{16'h0064, 16'h0000, 16'h0000, 16'h0032, 16'h001E,
      16'h0004, 16'h0BB8, 16'h0000, 16'h000A, 16'h03E8};
   logic [7:0] sel_v [5] = '{8'h07, 8'h06, 8'h04, 8'h08, 8'h10};
   logic [1:0] kind_v [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1};

   brm_monitor dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .speed_act(speed_act), .enc_error(enc_error), .resp(resp));
   brm_drive_model drv (.clock(clock), .rst(rst), .resp(resp), .set_speed(set_speed),
      .decel(decel), .enc_fault(enc_fault), .speed_act(speed_act), .enc_error(enc_error));

   // Clock and cycle count since reset release
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= rst ? 0 : cyc + 1;
   end

   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string m, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      if (n >= 50) chk("no pready", 32'h0000_0000, 32'h0000_0001);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee, string m);
      apb(1'b0, a, 32'h0000_0000, rdat, rerr);
      chk(m, rdat, e);
      chk(m, {31'h0, rerr}, {31'h0, ee});
   endtask : rdc

   task automatic ctl(input logic [7:0] v);
      apb(1'b1, REG_CTRL, {24'h00_0000, v}, rdat, rerr);
   endtask : ctl

   task automatic cfg(input int i, input logic [15:0] v);
      apb(1'b1, REG_CFG_BASE + 12'(4 * i), {16'h0000, v}, rdat, rerr);
   endtask : cfg

   // State and masked responses, from status and from the port
   task automatic st(input logic [2:0] s, input logic [6:0] r, input logic [6:0] k, string m);
      apb(1'b0, REG_STATUS, 32'h0000_0000, rdat, rerr);
      chk(m, {15'h0, rdat[15:13], rdat[6:0] & k, resp & k}, {15'h0, s, r & k, r & k});
   endtask : st

   // Step to just after the next monitoring tick
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clock);
         while (cyc % MON_CLKS != 20) begin
            @(posedge clock);
         end
      end
   endtask : tick

   task automatic done(input string m);
      $display("test %s done", m);
   endtask : done

   // Hang guard, a little beyond the planned 28 monitoring cycles
   initial begin
      repeat (95000) @(posedge clock);
      chk("watchdog", 32'h0000_0000, 32'h0000_0001);
      close_out();
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      set_speed = 16'h0000;
      decel = 16'h0000;
      enc_fault = 1'b0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rdc(REG_ACC_LIM, 32'h0000_FFFF, 1'b0, "limit reset");
      rdc(12'h100, 32'h0000_0000, 1'b1, "unmapped");
      rdc(12'h002, 32'h0000_0000, 1'b1, "misaligned");
      apb(1'b1, REG_STATUS, 32'hFFFF_FFFF, rdat, rerr);
      rdc(REG_STATUS, 32'h0000_0000, 1'b0, "status ro");
      for (int i = 0; i < CFG_N; i++) begin
         rdc(REG_CFG_BASE + 12'(4 * i), 32'h0000_0000, 1'b0, "cfg reset");
         cfg(i, cfg_v[i]);
         rdc(REG_CFG_BASE + 12'(4 * i), {16'h0000, cfg_v[i]}, 1'b0, "cfg rw");
      end
      done("registers");
      // Each stop kind and its priority, then deselect
      foreach (sel_v[i]) begin
         ctl(sel_v[i]);
         apb(1'b0, REG_STATUS, 32'h0000_0000, rdat, rerr);
         chk("kind", {27'h0, rdat[15:11]}, {27'h0, S_DLY, kind_v[i]});
         ctl(8'h00);
         st(S_IDL, 7'h00, 7'h7F, "deselect");
      end
      done("kinds");
      // Stop two without braking, speed stepped from 600 to 650
      set_speed <= 16'(600);
      tick(1);
      ctl(8'h02);
      st(S_DLY, QS, 7'h7F, "sel two");
      tick(1);
      rdc(REG_ACC_LIM, 32'(600 + TOL * FIRST_GAIN), 1'b0, "first");
      st(S_DLY, QS, 7'h7F, "min delay");
      tick(1);
      st(S_RMP, QS, 7'h7F, "ramp on");
      rdc(REG_ACC_LIM, 32'(600 + TOL), 1'b0, "track");
      apb(1'b0, REG_RAMP, 32'h0000_0000, r0, rerr);
      set_speed <= 16'(650);
      tick(1);
      rdc(REG_ACC_LIM, 32'(600 + TOL), 1'b0, "hold");
      rdc(REG_RAMP, r0 - 32'(3000 / 10), 1'b0, "gradient");
      tick(1);
      st(S_FOL, TQ, 7'h3F, "two end");
      ctl(8'h00);
      done("stop two");
      // Stop one, longer delay, reverse speed crossing the ramp
      cfg(CFG_RAMP_DELAY_TIME, 16'h0003);
      set_speed <= 16'(-2000);
      tick(1);
      ctl(8'h01);
      tick(2);
      st(S_DLY, QS, 7'h7F, "delay three");
      tick(1);
      st(S_RMP, QS, 7'h7F, "ramp three");
      tick(5);
      st(S_FLT, PC | VM, 7'h3F, "violation");
      set_speed <= 16'h0000;
      ctl(8'h80);
      st(S_IDL, 7'h00, 7'h7F, "ack");
      done("violation");
      // Encoder error with and without the option bit
      ctl(8'h41);
      enc_fault <= 1'b1;
      repeat (2) @(posedge clock);
      st(S_FLT, FS | TS, 7'h1F, "enc option");
      ctl(8'hC1);
      st(S_FLT, FS | TS, 7'h1F, "ack refused");
      enc_fault <= 1'b0;
      ctl(8'h80);
      st(S_IDL, 7'h00, 7'h7F, "enc ack");
      ctl(8'h01);
      enc_fault <= 1'b1;
      repeat (2) @(posedge clock);
      st(S_FLT, PC, 7'h0B, "enc plain");
      enc_fault <= 1'b0;
      ctl(8'h80);
      done("encoder");
      // Stop one ended by shutdown speed
      cfg(CFG_RAMP_DELAY_TIME, 16'h0002);
      set_speed <= 16'(1500);
      decel <= 16'(30);
      tick(1);
      ctl(8'h01);
      tick(6);
      st(S_FOL, TQ, 7'h3F, "shutdown");
      ctl(8'h00);
      decel <= 16'h0000;
      done("stop one");
      // Limited speed ended by dwell below the new level
      set_speed <= 16'(800);
      tick(1);
      ctl(8'h04);
      tick(6);
      st(S_FOL, SL, 7'h3F, "sls level");
      done("limited speed");
      close_out();
   end
endmodule : tb_top
